/* ddrt_pkg.sv */
// Operation
// - Two clocks after mode register set.
// - Row open 45/50 ns, close before 120 us.
// - Same-bank activate/refresh spacing 65/70 ns.
// - Refresh to activate/refresh 75/80 ns.
// - Activate to read/write 20 ns.
// - Precharge to activate 20 ns.
// - Auto-precharge access waits activate-to-autoprecharge delay.
// - Activates to different banks 15 ns apart.
// - Write recovery 15 ns before precharge.
// - Write auto-precharge: rounded recovery plus precharge.
// - One clock from write end to read.
// - Self-refresh exit to non-read 75/80 ns.
// - Self-refresh exit to read 200 clocks.
// - Average refresh interval at most 7.8 us.
// - At most eight refreshes owed.
// - Write preamble from high impedance, quarter clock.
// - Write postamble between 0.40 and 0.60 clocks.
// - Strobe falling edge 0.2 clocks from clock.
// - Strobe phases at least 0.35 clocks.
// - First strobe edge 0.75 to 1.25 clocks.
package ddrt_pkg;
	// System clock period and the divider that makes the memory clock.
	localparam int SYS_PERIOD_NS = 100;
	localparam int CK_DIV = 2;
	localparam int TCK_NS = SYS_PERIOD_NS * CK_DIV;
	// Counter width, bank count and address widths.
	localparam int CW = 10;
	localparam int NUM_BANKS = 4;
	localparam int BA_W = 2;
	localparam int ADDR_W = 13;
	localparam int AP_BIT = 10;
	localparam int BURST_LEN = 4;
	// Minimum and maximum times, fast grades first, slowest grade second.
	localparam int TRAS_MIN_NS = 45;
	localparam int TRAS_MIN_SLOW_NS = 50;
	localparam int TRAS_MAX_NS = 120000;
	localparam int TRC_NS = 65;
	localparam int TRC_SLOW_NS = 70;
	localparam int TRFC_NS = 75;
	localparam int TRFC_SLOW_NS = 80;
	localparam int TRCD_NS = 20;
	localparam int TRP_NS = 20;
	localparam int TRRD_NS = 15;
	localparam int TWR_NS = 15;
	localparam int TXSNR_NS = 75;
	localparam int TXSNR_SLOW_NS = 80;
	localparam real TREFI_US = 7.8;
	// Times given directly in memory clocks, and the limit on refreshes owed.
	localparam int TMRD_CK = 2;
	localparam int TWTR_CK = 1;
	localparam int TXSRD_CK = 200;
	localparam int REF_OWED_MAX = 8;
	localparam int RAS_GUARD_CK = 16;
	// Longest times round down to whole memory clocks.
	localparam int TRAS_MAX_CK = TRAS_MAX_NS / TCK_NS;
	localparam int TREFI_CK = int'($floor(TREFI_US * 1000.0 / TCK_NS));
	// Write strobe steps in system cycles, each half a memory clock, counted from the write.
	localparam logic [2:0] WSEQ_PRE = 3'h2;
	localparam logic [2:0] WSEQ_FIRST = 3'h3;
	localparam logic [2:0] WSEQ_LAST = 3'h6;
	localparam logic [2:0] WSEQ_END = 3'h7;
	// Command pins {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] PIN_NOP = 4'h7;
	localparam logic [3:0] PIN_ACT = 4'h3;
	localparam logic [3:0] PIN_RD = 4'h5;
	localparam logic [3:0] PIN_WR = 4'h4;
	localparam logic [3:0] PIN_PRE = 4'h2;
	localparam logic [3:0] PIN_REF = 4'h1;
	localparam logic [3:0] PIN_MRS = 4'h0;
	typedef enum logic [1:0] {DDRT_G266A = 2'b00, DDRT_G266 = 2'b01, DDRT_G200 = 2'b10} ddrt_grade_e;
	typedef enum logic [3:0] {
		DDRT_NOP = 4'b0000, DDRT_MRS = 4'b0001, DDRT_ACT = 4'b0010, DDRT_RD = 4'b0011,
		DDRT_WR = 4'b0100, DDRT_PRE = 4'b0101, DDRT_PREALL = 4'b0110, DDRT_REF = 4'b0111,
		DDRT_SRE = 4'b1000, DDRT_SRX = 4'b1001
	} ddrt_cmd_e;
	// Ceiling division of a minimum time by the memory clock, at least one clock.
	function automatic int ns2ck(input int ns);
		ns2ck = (ns + TCK_NS - 1) / TCK_NS;
		if (ns2ck < 1) begin
			ns2ck = 1;
		end
	endfunction
	// Load value that lets a command through exactly the given number of clocks later.
	function automatic logic [CW-1:0] ld(input int ck);
		ld = CW'(ck - 1);
	endfunction
	// Picks the slowest-grade figure or the faster-grade figure.
	function automatic int by_grade(input ddrt_grade_e g, input int fast_ns, input int slow_ns);
		by_grade = (g == DDRT_G200) ? slow_ns : fast_ns;
	endfunction
	// Down-counter step: a load wins, else count down on a clock tick until zero.
	function automatic logic [CW-1:0] step(input logic [CW-1:0] cnt, input logic load,
		input logic [CW-1:0] val, input logic tick);
		if (load) begin
			step = val;
		end else if (tick && cnt != '0) begin
			step = cnt - 1'b1;
		end else begin
			step = cnt;
		end
	endfunction
endpackage

/* ddrt_bank_if.sv */
`timescale 1ns/1ns
// Events from the command guard to one bank timer, and that bank's permissions back.
interface ddrt_bank_if;
	logic tick; // One memory clock has passed.
	logic act; // Activate to this bank.
	logic rd; // Read to this bank.
	logic wr; // Write to this bank.
	logic ap; // The read or write carries auto-precharge.
	logic pre; // Precharge to this bank.
	logic refr; // Refresh or self-refresh entry, all banks.
	logic wr_end; // Last write data of this bank's burst.
	logic open; // A row is open.
	logic ok_act; // An activate may go now.
	logic ok_rw; // A plain read or write may go now.
	logic ok_ap; // A read or write with auto-precharge may go now.
	logic ok_pre; // A precharge may go now.
	logic ras_due; // The row has been open nearly as long as allowed.
	modport ctl(output tick, act, rd, wr, ap, pre, refr, wr_end,
		input open, ok_act, ok_rw, ok_ap, ok_pre, ras_due);
	modport bank(input tick, act, rd, wr, ap, pre, refr, wr_end,
		output open, ok_act, ok_rw, ok_ap, ok_pre, ras_due);
endinterface

/* ddrt_bank_timer.sv */
`timescale 1ns/1ns
// Per-bank timing counters; all loads happen on memory clock ticks.
module ddrt_bank_timer #(
	parameter ddrt_pkg::ddrt_grade_e GRADE = ddrt_pkg::DDRT_G266A
) (
	input wire logic clk,
	input wire logic reset_n,
	ddrt_bank_if.bank bi
);
	import ddrt_pkg::*;
	localparam logic [CW-1:0] RC_LD = ld(ns2ck(by_grade(GRADE, TRC_NS, TRC_SLOW_NS)));
	localparam logic [CW-1:0] RAS_LD = ld(ns2ck(by_grade(GRADE, TRAS_MIN_NS, TRAS_MIN_SLOW_NS)));
	localparam logic [CW-1:0] RCD_LD = ld(ns2ck(TRCD_NS));
	localparam logic [CW-1:0] RP_LD = ld(ns2ck(TRP_NS));
	localparam logic [CW-1:0] WR_LD = ld(ns2ck(TWR_NS));
	localparam logic [CW-1:0] DAL_LD = ld(ns2ck(TWR_NS) + ns2ck(TRP_NS));
	localparam logic [CW-1:0] RDAP_LD = ld(BURST_LEN / 2 + ns2ck(TRP_NS));
	localparam logic [CW-1:0] RAS_DUE = CW'(TRAS_MAX_CK - RAS_GUARD_CK);
	logic [CW-1:0] rc_cnt; // Activate or refresh to next activate.
	logic [CW-1:0] rp_cnt; // Precharge in progress.
	logic [CW-1:0] rcd_cnt; // Activate to column access.
	logic [CW-1:0] ras_cnt; // Least row-open time.
	logic [CW-1:0] wr_cnt; // Write recovery.
	logic [CW-1:0] age; // Clocks since the row was opened.
	logic is_open; // Row open.
	logic wr_busy; // Write burst still on the strobe.
	logic wr_ap; // Pending write carries auto-precharge.
	// Spacing counters, all four in one process.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rc_cnt <= '0;
			rcd_cnt <= '0;
			ras_cnt <= '0;
			wr_cnt <= '0;
		end else begin
			rc_cnt <= step(rc_cnt, bi.act || bi.refr, RC_LD, bi.tick);
			rcd_cnt <= step(rcd_cnt, bi.act, RCD_LD, bi.tick);
			ras_cnt <= step(ras_cnt, bi.act, RAS_LD, bi.tick);
			wr_cnt <= step(wr_cnt, bi.wr_end, WR_LD, bi.tick);
		end
	end
	// Precharge time, stretched for write auto-precharge by the rounded recovery sum and for read auto-precharge by half the burst.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rp_cnt <= '0;
		end else if (bi.wr_end && wr_ap) begin
			rp_cnt <= DAL_LD;
		end else if (bi.rd && bi.ap) begin
			rp_cnt <= RDAP_LD;
		end else begin
			rp_cnt <= step(rp_cnt, bi.pre && is_open, RP_LD, bi.tick);
		end
	end
	// Row state, write burst state and row age.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			is_open <= 1'b0;
			wr_busy <= 1'b0;
			wr_ap <= 1'b0;
			age <= '0;
		end else begin
			if (bi.act) begin
				is_open <= 1'b1;
			end else if (bi.pre || ((bi.rd || bi.wr) && bi.ap)) begin
				is_open <= 1'b0;
			end
			if (bi.wr) begin
				wr_busy <= 1'b1;
				wr_ap <= bi.ap;
			end else if (bi.wr_end) begin
				wr_busy <= 1'b0;
			end
			if (bi.act) begin
				age <= '0;
			end else if (bi.tick && is_open && age != '1) begin
				age <= age + 1'b1;
			end
		end
	end
	assign bi.open = is_open;
	assign bi.ok_act = !is_open && !wr_busy && rc_cnt == '0 && rp_cnt == '0;
	assign bi.ok_rw = is_open && !wr_busy && rcd_cnt == '0;
	assign bi.ok_ap = is_open && !wr_busy && rcd_cnt == '0 && ras_cnt == '0;
	assign bi.ok_pre = !wr_busy && wr_cnt == '0 && (!is_open || ras_cnt == '0);
	assign bi.ras_due = is_open && age >= RAS_DUE;
endmodule

/* ddrt_refresh.sv */
`timescale 1ns/1ns
// Counts refreshes owed to the memory, one per average refresh interval.
module ddrt_refresh #(
	parameter int REFI_CK = ddrt_pkg::TREFI_CK
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tick,
	input wire logic ref_done,
	input wire logic self_ref,
	output logic [3:0] owed,
	output logic urgent
);
	import ddrt_pkg::*;
	logic [CW-1:0] ivl; // Clocks left in the current interval.
	logic due; // This tick closes an interval.
	assign due = tick && ivl == '0;
	// Interval timer; it restarts while the memory refreshes itself.
	always_ff @(posedge clk) begin
		if (!reset_n || self_ref) begin
			ivl <= CW'(REFI_CK - 1);
		end else begin
			ivl <= due ? CW'(REFI_CK - 1) : step(ivl, 1'b0, '0, tick);
		end
	end
	// Owed count; an interval ending in the cycle of a refresh leaves it unchanged.
	always_ff @(posedge clk) begin
		if (!reset_n || self_ref) begin
			owed <= 4'h0;
		end else if (due && !ref_done) begin
			owed <= owed + 4'h1;
		end else if (!due && ref_done && owed != 4'h0) begin
			owed <= owed - 4'h1;
		end
	end
	assign urgent = owed >= 4'(REF_OWED_MAX - 1);
endmodule

/* ddrt_guard.sv */
`timescale 1ns/1ns
// Command timing guard and refresh scheduler in front of a DDR memory.
// User commands are held until every spacing is met; row age and urgent
// refresh debt are served first, by commands that the guard makes itself.
module ddrt_guard #(
	parameter ddrt_pkg::ddrt_grade_e GRADE = ddrt_pkg::DDRT_G266A,
	parameter int REFI_CK = ddrt_pkg::TREFI_CK
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire ddrt_pkg::ddrt_cmd_e cmd_code,
	input wire logic [ddrt_pkg::BA_W-1:0] cmd_bank,
	input wire logic [ddrt_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic cmd_ap,
	output logic cmd_done,
	output logic sr_active,
	output logic [3:0] refresh_owed,
	output logic ddr_ck,
	output logic ddr_cke,
	output logic ddr_cs_n,
	output logic ddr_ras_n,
	output logic ddr_cas_n,
	output logic ddr_we_n,
	output logic [ddrt_pkg::BA_W-1:0] ddr_ba,
	output logic [ddrt_pkg::ADDR_W-1:0] ddr_a,
	output logic ddr_dqs,
	output logic ddr_dqs_oe,
	output logic wr_beat
);
	import ddrt_pkg::*;

	// Global load values, in memory clocks.
	localparam logic [CW-1:0] MRD_LD = ld(TMRD_CK);
	localparam logic [CW-1:0] RRD_LD = ld(ns2ck(TRRD_NS));
	localparam logic [CW-1:0] RFC_LD = ld(ns2ck(by_grade(GRADE, TRFC_NS, TRFC_SLOW_NS)));
	localparam logic [CW-1:0] XSNR_LD = ld(ns2ck(by_grade(GRADE, TXSNR_NS, TXSNR_SLOW_NS)));
	localparam logic [CW-1:0] XSRD_LD = ld(TXSRD_CK);
	localparam logic [CW-1:0] WTR_LD = ld(TWTR_CK);

	// Returns the lowest set bit index of a bank vector.
	function automatic logic [BA_W-1:0] first_set(input logic [NUM_BANKS-1:0] v);
		first_set = '0;
		for (int k = NUM_BANKS - 1; k >= 0; k--) begin
			if (v[k]) begin
				first_set = BA_W'(k);
			end
		end
	endfunction

	// Maps a command to its pin pattern.
	function automatic logic [3:0] pins_of(input ddrt_cmd_e c);
		case (c)
			DDRT_MRS: pins_of = PIN_MRS;
			DDRT_ACT: pins_of = PIN_ACT;
			DDRT_RD: pins_of = PIN_RD;
			DDRT_WR: pins_of = PIN_WR;
			DDRT_PRE, DDRT_PREALL: pins_of = PIN_PRE;
			DDRT_REF, DDRT_SRE: pins_of = PIN_REF;
			default: pins_of = PIN_NOP;
		endcase
	endfunction

	logic slot; // Edge at which the memory clock falls and new pins are launched.
	logic [CW-1:0] mrd_cnt; // Mode register set to any command.
	logic [CW-1:0] rrd_cnt; // Activate to activate in another bank.
	logic [CW-1:0] rfc_cnt; // Refresh to activate or refresh.
	logic [CW-1:0] xsnr_cnt; // Self-refresh exit to non-read command.
	logic [CW-1:0] xsrd_cnt; // Self-refresh exit to read.
	logic [CW-1:0] wtr_cnt; // Write end to read.
	logic [2:0] wcnt; // Write strobe step, zero when idle.
	logic [BA_W-1:0] wr_bank; // Bank of the write on the strobe.
	logic wr_end; // Last write data leaves in this cycle.
	logic owed_urgent; // Refresh debt is one short of its limit.
	logic [NUM_BANKS-1:0] b_open, b_ok_act, b_ok_rw, b_ok_ap, b_ok_pre, b_due;
	logic all_closed; // No bank has an open row.
	logic ref_ok; // A refresh may go now.
	logic user_ok; // The presented command may go now.
	ddrt_cmd_e issue; // Command launched at this edge.
	logic [BA_W-1:0] issue_bank; // Its bank.
	logic issue_ap; // Its auto-precharge flag.
	logic issue_user; // It came from the user port.

	assign slot = ddr_ck;
	assign wr_end = wcnt == WSEQ_LAST;

	// One bank timer per bank, each fed by its own event strobes.
	for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
		ddrt_bank_if bif();
		ddrt_bank_timer #(.GRADE(GRADE)) u_timer (
			.clk(sys_clk),
			.reset_n(reset_n),
			.bi(bif.bank)
		);
		assign bif.tick = slot;
		assign bif.act = issue == DDRT_ACT && issue_bank == BA_W'(i);
		assign bif.rd = issue == DDRT_RD && issue_bank == BA_W'(i);
		assign bif.wr = issue == DDRT_WR && issue_bank == BA_W'(i);
		assign bif.ap = issue_ap;
		assign bif.pre = issue == DDRT_PREALL || (issue == DDRT_PRE && issue_bank == BA_W'(i));
		assign bif.refr = issue == DDRT_REF || issue == DDRT_SRE;
		assign bif.wr_end = wr_end && wr_bank == BA_W'(i);
		assign b_open[i] = bif.open;
		assign b_ok_act[i] = bif.ok_act;
		assign b_ok_rw[i] = bif.ok_rw;
		assign b_ok_ap[i] = bif.ok_ap;
		assign b_ok_pre[i] = bif.ok_pre;
		assign b_due[i] = bif.ras_due && bif.ok_pre;
	end

	// Refresh debt; the owed count is a flip-flop inside the scheduler.
	ddrt_refresh #(.REFI_CK(REFI_CK)) u_refresh (
		.clk(sys_clk),
		.reset_n(reset_n),
		.tick(slot),
		.ref_done(issue == DDRT_REF),
		.self_ref(sr_active),
		.owed(refresh_owed),
		.urgent(owed_urgent)
	);

	assign all_closed = ~|b_open;
	// Refresh needs every bank idle and past its activate and precharge spacing.
	assign ref_ok = &b_ok_act && rfc_cnt == '0 && xsnr_cnt == '0 && mrd_cnt == '0;

	// Checks the presented command against every spacing that applies to it.
	always_comb begin
		user_ok = 1'b0;
		if (sr_active) begin
			user_ok = cmd_code == DDRT_SRX;
		end else if (mrd_cnt == '0 && xsnr_cnt == '0) begin
			case (cmd_code)
				// A no-operation is taken at once and simply sends an idle slot.
				DDRT_NOP: user_ok = 1'b1;
				DDRT_MRS: user_ok = all_closed && wcnt == '0;
				DDRT_ACT: user_ok = b_ok_act[cmd_bank] && rrd_cnt == '0 && rfc_cnt == '0;
				DDRT_RD: user_ok = (cmd_ap ? b_ok_ap[cmd_bank] : b_ok_rw[cmd_bank])
					&& wcnt == '0 && wtr_cnt == '0 && xsrd_cnt == '0;
				DDRT_WR: user_ok = (cmd_ap ? b_ok_ap[cmd_bank] : b_ok_rw[cmd_bank])
					&& wcnt == '0;
				DDRT_PRE: user_ok = b_ok_pre[cmd_bank];
				DDRT_PREALL: user_ok = &b_ok_pre;
				DDRT_REF, DDRT_SRE: user_ok = ref_ok;
				default: user_ok = 1'b0;
			endcase
		end
	end

	// Chooses the command for this edge: row age first, then refresh debt, then the user.
	always_comb begin
		issue = DDRT_NOP;
		issue_bank = cmd_bank;
		issue_ap = 1'b0;
		issue_user = 1'b0;
		if (!slot || !reset_n) begin
			issue = DDRT_NOP;
		end else if (!sr_active && |b_due && mrd_cnt == '0) begin
			issue = DDRT_PRE;
			issue_bank = first_set(b_due);
		end else if (!sr_active && owed_urgent) begin
			if (!all_closed && &b_ok_pre && mrd_cnt == '0) begin
				issue = DDRT_PREALL;
			end else if (all_closed && ref_ok) begin
				issue = DDRT_REF;
			end
		end else if (cmd_valid && user_ok) begin
			issue = cmd_code;
			issue_ap = cmd_ap && (cmd_code == DDRT_RD || cmd_code == DDRT_WR);
			issue_user = 1'b1;
		end
	end

	// Memory clock: the system clock divided by two.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ddr_ck <= 1'b0;
		end else begin
			ddr_ck <= ~ddr_ck;
		end
	end

	// Command pins change only at slots, half a memory clock before the memory samples them.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			{ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_NOP;
			ddr_ba <= '0;
			ddr_a <= '0;
		end else if (slot) begin
			{ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= pins_of(issue);
			ddr_ba <= issue_bank;
			ddr_a <= cmd_addr;
			if (issue == DDRT_RD || issue == DDRT_WR) begin
				ddr_a[AP_BIT] <= issue_ap;
			end else if (issue == DDRT_PRE || issue == DDRT_PREALL) begin
				ddr_a <= '0;
				ddr_a[AP_BIT] <= issue == DDRT_PREALL;
			end
		end
	end

	// Clock enable and self-refresh state.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ddr_cke <= 1'b0;
			sr_active <= 1'b0;
		end else if (issue == DDRT_SRE) begin
			ddr_cke <= 1'b0;
			sr_active <= 1'b1;
		end else if (issue == DDRT_SRX) begin
			ddr_cke <= 1'b1;
			sr_active <= 1'b0;
		end else if (!sr_active) begin
			ddr_cke <= 1'b1;
		end
	end

	// Spacing counters shared by all banks.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mrd_cnt <= '0;
			rrd_cnt <= '0;
			rfc_cnt <= '0;
			xsnr_cnt <= '0;
			xsrd_cnt <= '0;
			wtr_cnt <= '0;
		end else begin
			mrd_cnt <= step(mrd_cnt, issue == DDRT_MRS, MRD_LD, slot);
			rrd_cnt <= step(rrd_cnt, issue == DDRT_ACT, RRD_LD, slot);
			rfc_cnt <= step(rfc_cnt, issue == DDRT_REF, RFC_LD, slot);
			xsnr_cnt <= step(xsnr_cnt, issue == DDRT_SRX, XSNR_LD, slot);
			xsrd_cnt <= step(xsrd_cnt, issue == DDRT_SRX, XSRD_LD, slot);
			wtr_cnt <= step(wtr_cnt, wr_end, WTR_LD, slot);
		end
	end

	// Write strobe step counter; one write burst on the strobe at a time.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wcnt <= '0;
			wr_bank <= '0;
		end else if (issue == DDRT_WR) begin
			wcnt <= 3'h1;
			wr_bank <= issue_bank;
		end else if (wcnt == WSEQ_END) begin
			wcnt <= '0;
		end else if (wcnt != '0) begin
			wcnt <= wcnt + 3'h1;
		end
	end

	// Write strobe: a half-clock low preamble out of high impedance, first rising
	// edge one memory clock after the write is sampled, half-clock phases that
	// fall midway between clock rises, and a half-clock low postamble.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ddr_dqs <= 1'b0;
			ddr_dqs_oe <= 1'b0;
			wr_beat <= 1'b0;
		end else begin
			ddr_dqs_oe <= wcnt >= WSEQ_PRE && wcnt < WSEQ_END;
			ddr_dqs <= wcnt >= WSEQ_FIRST && wcnt <= WSEQ_LAST && wcnt[0];
			wr_beat <= wcnt >= WSEQ_FIRST && wcnt <= WSEQ_LAST;
		end
	end

	// Acknowledge to the user, raised at the same edge that puts its command on the pins.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cmd_done <= 1'b0;
		end else begin
			cmd_done <= issue_user;
		end
	end
endmodule

/* ddrt_guard_properties.sv */
`timescale 1ns/1ns
// Watches the memory pins and write strobe of the guard.
module ddrt_guard_chk (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic sr_active,
	input wire logic [3:0] refresh_owed,
	input wire logic ddr_ck,
	input wire logic ddr_cs_n,
	input wire logic ddr_ras_n,
	input wire logic ddr_cas_n,
	input wire logic ddr_we_n,
	input wire logic ddr_dqs,
	input wire logic ddr_dqs_oe
);
	import ddrt_pkg::*;
	logic [3:0] pins; // Command pins as one code.
	logic [15:0] xs; // Cycles since self-refresh ended.
	logic sx; // Self-refresh has been used.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	assign pins = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
	// Counts cycles after self-refresh, saturating so it never wraps.
	always_ff @(posedge sys_clk) begin
		if (!reset_n || sr_active) begin
			xs <= '0;
		end else if (xs != 16'hffff) begin
			xs <= xs + 16'h1;
		end
	end
	// Remembers self-refresh, so the count means nothing before it.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sx <= 1'b0;
		end else if (sr_active) begin
			sx <= 1'b1;
		end
	end
	sequence s_new(logic [3:0] code);
		pins == code && $past(pins) != code;
	endsequence
	sequence s_burst;
		ddr_dqs_oe && !ddr_dqs ##1 ddr_dqs ##1 !ddr_dqs ##1 ddr_dqs ##1 !ddr_dqs ##1 !ddr_dqs_oe;
	endsequence
	property p_mrd;
		s_new(PIN_MRS) |-> ##2 pins == PIN_NOP;
	endproperty
	a_mrd: assert property (p_mrd) else $error("command too soon after mode set");
	property p_pre;
		s_new(PIN_WR) |-> ##1 !ddr_dqs_oe ##1 (ddr_dqs_oe && !ddr_dqs);
	endproperty
	a_pre: assert property (p_pre) else $error("bad write preamble");
	property p_burst;
		s_new(PIN_WR) |-> ##2 s_burst;
	endproperty
	a_burst: assert property (p_burst) else $error("bad strobe burst");
	property p_post;
		$fell(ddr_dqs_oe) |-> !$past(ddr_dqs) && $past(ddr_dqs, 2);
	endproperty
	a_post: assert property (p_post) else $error("bad write postamble");
	property p_fall;
		ddr_dqs_oe && $fell(ddr_dqs) |-> !ddr_ck;
	endproperty
	a_fall: assert property (p_fall) else $error("strobe fall off clock");
	property p_slot;
		$changed(pins) |-> !ddr_ck;
	endproperty
	a_slot: assert property (p_slot) else $error("command off slot");
	property p_owed;
		refresh_owed <= 4'(REF_OWED_MAX);
	endproperty
	a_owed: assert property (p_owed) else $error("too many refreshes owed");
	property p_xsrd;
		sx && pins == PIN_RD && $past(pins) != PIN_RD |-> xs >= 16'h18f;
	endproperty
	a_xsrd: assert property (p_xsrd) else $error("read too soon after self-refresh");
endmodule
bind ddrt_guard ddrt_guard_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.sr_active(sr_active), .refresh_owed(refresh_owed), .ddr_ck(ddr_ck),
	.ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
	.ddr_we_n(ddr_we_n), .ddr_dqs(ddr_dqs), .ddr_dqs_oe(ddr_dqs_oe));

/* ddrt_mem_model.sv */
`timescale 1ns/1ns
// Memory side: takes a command at each memory clock rise and counts spacing faults.
module ddrt_mem_model (
	input wire logic sys_clk,
	input wire logic ddr_ck,
	input wire logic ddr_cke,
	input wire logic [3:0] pins,
	input wire logic [ddrt_pkg::BA_W-1:0] ddr_ba,
	input wire logic [ddrt_pkg::ADDR_W-1:0] ddr_a
);
	import ddrt_pkg::*;
	int faults = 0, refs = 0, m = 0, tm = -99, tr = -99, tw = -99, tx = -999, tl = -99, b;
	int ta[4] = '{default: -999};
	int tp[4] = '{default: -999};
	logic [3:0] op = '0; // Open rows, one bit a bank.
	logic in_sr = 1'b0; // Memory is in self-refresh.
	// Whole memory clocks that cover a time.
	function automatic int c(input int ns);
		return (ns + TCK_NS - 1) / TCK_NS;
	endfunction
	task automatic need(input logic ok);
		if (!ok) faults++;
	endtask
	// The memory samples while its clock rises; with the clock enable low only entry counts.
	always @(posedge sys_clk) begin
		if (!ddr_ck && (ddr_cke || pins == PIN_REF)) begin
			m++;
			b = int'(ddr_ba);
			if (in_sr && ddr_cke) tx = m;
			if (pins != PIN_NOP) need(m - tm >= TMRD_CK);
			if (pins != PIN_NOP && pins != PIN_RD) need(m - tx >= c(TXSNR_NS));
			case (pins)
				PIN_MRS: tm = m;
				PIN_ACT: begin
					need(!op[b] && m - tp[b] >= c(TRP_NS) && m - ta[b] >= c(TRC_NS));
					need(m - tl >= c(TRRD_NS) && m - tr >= c(TRFC_NS));
					op[b] = 1'b1;
					ta[b] = m;
					tl = m;
				end
				PIN_RD, PIN_WR: begin
					need(op[b] && m - ta[b] >= c(TRCD_NS));
					if (pins == PIN_RD) need(m - tw >= TWTR_CK && m - tx >= TXSRD_CK);
					else tw = m + BURST_LEN / 2;
					if (ddr_a[AP_BIT]) begin
						need(m - ta[b] >= c(TRAS_MIN_NS));
						op[b] = 1'b0;
						tp[b] = pins == PIN_WR ? tw + c(TWR_NS) : m + BURST_LEN / 2;
					end
				end
				PIN_PRE: for (int i = 0; i < 4; i++) begin
					if (op[i] && (ddr_a[AP_BIT] || i == b)) begin
						need(m - ta[i] >= c(TRAS_MIN_NS) && m - ta[i] <= TRAS_MAX_CK);
						need(m - tw >= c(TWR_NS));
						op[i] = 1'b0;
						tp[i] = m;
					end
				end
				PIN_REF: begin
					need(op == 0 && m - tr >= c(TRFC_NS) && m - tl >= c(TRC_NS));
					tr = m;
					refs++;
				end
				default: ;
			endcase
			in_sr = !ddr_cke;
		end
	end
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
// Random and corner command streams through the guard, checked at the memory pins.
module tb_top;
	import ddrt_pkg::*;
	logic sys_clk = 0, reset_n = 0, cmd_valid = 0, cmd_ap = 0, ap;
	ddrt_cmd_e cmd_code = DDRT_NOP;
	logic [1:0] cmd_bank = '0, b, ddr_ba;
	logic [12:0] cmd_addr = '0, ddr_a;
	logic cmd_done, sr_active, ddr_ck, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
	logic ddr_dqs, ddr_dqs_oe, wr_beat;
	logic [3:0] refresh_owed, pins;
	int bad_count = 0, comparisons = 0, r0;
	time t0;
	assign pins = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
	ddrt_guard u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_ap(cmd_ap),
		.cmd_done(cmd_done), .sr_active(sr_active), .refresh_owed(refresh_owed),
		.ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
		.ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_a(ddr_a),
		.ddr_dqs(ddr_dqs), .ddr_dqs_oe(ddr_dqs_oe), .wr_beat(wr_beat));
	ddrt_mem_model u_mem (.sys_clk(sys_clk), .ddr_ck(ddr_ck), .ddr_cke(ddr_cke),
		.pins(pins), .ddr_ba(ddr_ba), .ddr_a(ddr_a));
	// Free-running system clock.
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic print_verdict();
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Pin code that each user command must put on the bus.
	function automatic logic [3:0] exp_pins(input ddrt_cmd_e c);
		case (c)
			DDRT_MRS: return PIN_MRS;
			DDRT_ACT: return PIN_ACT;
			DDRT_RD: return PIN_RD;
			DDRT_WR: return PIN_WR;
			DDRT_PRE, DDRT_PREALL: return PIN_PRE;
			DDRT_REF, DDRT_SRE: return PIN_REF;
			default: return PIN_NOP;
		endcase
	endfunction
	// Presents one command, waits for it to go out, then checks the pins.
	task automatic issue(input ddrt_cmd_e c, input logic [1:0] bk, input logic a);
		int n;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_bank = bk;
		cmd_addr = 13'($urandom);
		cmd_ap = a;
		n = 0;
		while (cmd_done !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			if (n > 1000) begin
				bad_count++;
				print_verdict();
			end
		end
		cmd_valid = 1'b0;
		check(16'(pins), 16'(exp_pins(c)));
		if (c == DDRT_RD || c == DDRT_WR) check(16'(ddr_a[AP_BIT]), 16'(a));
		if (c inside {DDRT_ACT, DDRT_RD, DDRT_WR, DDRT_PRE}) check(16'(ddr_ba), 16'(bk));
		if (c == DDRT_ACT) check(16'(ddr_a), 16'(cmd_addr));
	endtask
	// Counts strobe-driven cycles and data beats of one write.
	task automatic strobe();
		int n1, n2;
		n1 = 0;
		n2 = 0;
		repeat (8) begin
			@(negedge sys_clk);
			n1 += int'(ddr_dqs_oe);
			n2 += int'(wr_beat);
		end
		check(16'(n1), 16'h5);
		check(16'(n2), 16'h4);
	endtask
	// Main sequence: corners first, then random rows, self-refresh and refresh debt.
	initial begin
		void'($urandom(32'heca3de39));
		repeat (20) @(negedge sys_clk);
		reset_n = 1'b1;
		issue(DDRT_NOP, 2'h0, 1'b0);
		issue(DDRT_MRS, 2'h0, 1'b0);
		issue(DDRT_ACT, 2'h1, 1'b0);
		issue(DDRT_PRE, 2'h1, 1'b0);
		repeat (24) begin
			b = 2'($urandom);
			ap = 1'($urandom);
			issue(DDRT_PREALL, 2'h0, 1'b0);
			repeat (9) if (refresh_owed !== 4'h0) issue(DDRT_REF, 2'h0, 1'b0);
			issue(DDRT_ACT, b, 1'b0);
			issue(DDRT_ACT, b + 2'h1, 1'b0);
			if ($urandom % 2) begin
				issue(DDRT_WR, b, ap);
				fork strobe(); issue(DDRT_RD, b + 2'h1, 1'b0); join
			end else issue(DDRT_RD, b, ap);
			if (!ap) issue(DDRT_PRE, b, 1'b0);
		end
		issue(DDRT_PREALL, 2'h0, 1'b0);
		issue(DDRT_SRE, 2'h0, 1'b0);
		repeat (4) @(negedge sys_clk);
		check(16'({sr_active, ddr_cke, refresh_owed}), 16'h20);
		issue(DDRT_SRX, 2'h0, 1'b0);
		t0 = $time;
		issue(DDRT_ACT, 2'h0, 1'b0);
		issue(DDRT_RD, 2'h0, 1'b0);
		check(16'(($time - t0) >= 40000), 16'h1);
		issue(DDRT_PRE, 2'h0, 1'b0);
		r0 = u_mem.refs;
		repeat (800) @(negedge sys_clk);
		check(16'(u_mem.refs - r0 >= 2), 16'h1);
		check(16'(refresh_owed <= 4'h8), 16'h1);
		check(16'(u_mem.faults), 16'h0);
		print_verdict();
	end
endmodule
